// [hw/interrupt_priority_config.v]
/*
  Interrupt priority configuration: three 16-bit priority select
  registers, each 2-bit field disabling one request or giving it
  level 0, 1 or 2, decoded into enable and level outputs; the two-wire general field, with no enable output, decodes only to its level.
  Assumes a single clock, synchronous inputs, a plain register port
  with one-cycle strobes and an arbiter that reads the decoded outputs.
*/
`timescale 1ns/100ps
`default_nettype none
`include "prio_cfg_consts.vh"

module interrupt_priority_config (
  input  wire                 clk_i,
  input  wire                 reset_i,
  input  wire                 ce_i,
  input  wire [`ADDR_W-1:0]   addr_i,
  input  wire [`DATA_W-1:0]   wr_data_i,
  input  wire                 wr_i,
  input  wire                 rd_i,
  output wire [`DATA_W-1:0]   rd_data_o,
  output wire                 reserved_write_o,
  output wire [`SRC_COUNT-1:0] src_enable_o,
  output wire [`SRC_COUNT-1:0] level0_set_o,
  output wire [`SRC_COUNT-1:0] level1_set_o,
  output wire [`SRC_COUNT-1:0] level2_set_o,
  output wire [1:0]           serial0_tx_empty_level_o,
  output wire [1:0]           spi0_tx_empty_level_o,
  output wire [1:0]           spi0_rx_full_level_o,
  output wire [1:0]           port_a_pin_level_o,
  output wire [1:0]           port_b_pin_level_o,
  output wire [1:0]           port_c_pin_level_o,
  output wire [1:0]           twowire_error_level_o,
  output wire [1:0]           serial0_rx_full_level_o,
  output wire [1:0]           serial0_rx_error_level_o,
  output wire [1:0]           serial0_tx_idle_level_o,
  output wire [1:0]           timer_ch3_level_o,
  output wire [1:0]           timer_ch2_level_o,
  output wire [1:0]           timer_ch1_level_o,
  output wire [1:0]           timer_ch0_level_o,
  output wire [1:0]           twowire_status_level_o,
  output wire [1:0]           twowire_transmit_level_o,
  output wire [1:0]           twowire_receive_level_o,
  output wire [1:0]           twowire_general_level_o
);

  localparam N = `SRC_COUNT;

  // map a stored field code onto the arbiter's level number
  function [1:0] level_of;
    input [1:0] field;
    begin
      case (field)
        `FIELD_LEVEL0: level_of = `LEVEL_ZERO;
        `FIELD_LEVEL1: level_of = `LEVEL_ONE;
        `FIELD_LEVEL2: level_of = `LEVEL_TWO;
        default:       level_of = `LEVEL_ZERO;
      endcase
    end
  endfunction

  function enable_of;
    input [1:0] field;
    begin
      enable_of = (field != `FIELD_OFF);
    end
  endfunction

  // write mask per offset; unmapped offsets give zero
  function [`DATA_W-1:0] mask_of;
    input [`ADDR_W-1:0] addr;
    begin
      case (addr)
        `OFS_SELECT_TWO:   mask_of = `MASK_SELECT_TWO;
        `OFS_SELECT_THREE: mask_of = `MASK_SELECT_THREE;
        `OFS_SELECT_FOUR:  mask_of = `MASK_SELECT_FOUR;
        default:           mask_of = `READ_IDLE;
      endcase
    end
  endfunction

  reg  [`DATA_W-1:0]   select_two_q;
  reg  [`DATA_W-1:0]   select_three_q;
  reg  [`DATA_W-1:0]   select_four_q;
  reg  [`DATA_W-1:0]   rd_data_q;
  reg  [`DATA_W-1:0]   rd_data_d;
  reg                  reserved_write_q;
  reg  [N-1:0]         enable_q;
  reg  [2*N-1:0]       level_q;
  reg  [N-1:0]         level0_q;
  reg  [N-1:0]         level1_q;
  reg  [N-1:0]         level2_q;
  reg  [1:0]           general_level_q;

  wire                 hit_two;
  wire                 hit_three;
  wire                 hit_four;
  wire                 mapped;
  wire [2*N-1:0]       field_w;
  wire [N-1:0]         enable_d;
  wire [2*N-1:0]       level_d;
  wire [N-1:0]         level0_d;
  wire [N-1:0]         level1_d;
  wire [N-1:0]         level2_d;

  assign hit_two   = (addr_i == `OFS_SELECT_TWO);
  assign hit_three = (addr_i == `OFS_SELECT_THREE);
  assign hit_four  = (addr_i == `OFS_SELECT_FOUR);
  assign mapped    = hit_two | hit_three | hit_four;

  // register writes; reserved bits are never stored
  always @(posedge clk_i) begin
    if (reset_i) begin
      select_two_q   <= `RESET_VALUE;
      select_three_q <= `RESET_VALUE;
      select_four_q  <= `RESET_VALUE;
    end else if (ce_i && wr_i) begin
      if (hit_two) begin
        select_two_q <= wr_data_i & `MASK_SELECT_TWO;
      end
      if (hit_three) begin
        select_three_q <= wr_data_i & `MASK_SELECT_THREE;
      end
      if (hit_four) begin
        select_four_q <= wr_data_i & `MASK_SELECT_FOUR;
      end
    end
  end

  // read mux; unmapped offsets answer zero
  always @* begin
    case (addr_i)
      `OFS_SELECT_TWO:   rd_data_d = select_two_q;
      `OFS_SELECT_THREE: rd_data_d = select_three_q;
      `OFS_SELECT_FOUR:  rd_data_d = select_four_q;
      default:           rd_data_d = `READ_IDLE;
    endcase
  end

  // read data stands until the next enabled cycle, zero otherwise
  always @(posedge clk_i) begin
    if (reset_i) begin
      rd_data_q <= `READ_IDLE;
    end else if (ce_i) begin
      if (rd_i) begin
        rd_data_q <= rd_data_d;
      end else begin
        rd_data_q <= `READ_IDLE;
      end
    end
  end

  // flags a write that broke the zero-in-reserved convention;
  // the data is still taken, reserved bits are dropped
  always @(posedge clk_i) begin
    if (reset_i) begin
      reserved_write_q <= 1'b0;
    end else if (ce_i) begin
      reserved_write_q <= wr_i & mapped &
        (|(wr_data_i & ~mask_of(addr_i)));
    end
  end

  // gather each source's field into one packed vector
  assign field_w[2*`SRC_SER0_TX_EMPTY +: 2] =
    select_two_q[`SER0_TX_EMPTY_LSB +: 2];
  assign field_w[2*`SRC_SPI0_TX_EMPTY +: 2] =
    select_two_q[`SPI0_TX_EMPTY_LSB +: 2];
  assign field_w[2*`SRC_SPI0_RX_FULL +: 2] =
    select_two_q[`SPI0_RX_FULL_LSB +: 2];
  assign field_w[2*`SRC_PORT_A +: 2] =
    select_two_q[`PORT_A_LSB +: 2];
  assign field_w[2*`SRC_PORT_B +: 2] =
    select_two_q[`PORT_B_LSB +: 2];
  assign field_w[2*`SRC_PORT_C +: 2] =
    select_two_q[`PORT_C_LSB +: 2];
  assign field_w[2*`SRC_TW_ERROR +: 2] =
    select_three_q[`TW_ERROR_LSB +: 2];
  assign field_w[2*`SRC_SER0_RX_FULL +: 2] =
    select_three_q[`SER0_RX_FULL_LSB +: 2];
  assign field_w[2*`SRC_SER0_RX_ERROR +: 2] =
    select_three_q[`SER0_RX_ERROR_LSB +: 2];
  assign field_w[2*`SRC_SER0_TX_IDLE +: 2] =
    select_three_q[`SER0_TX_IDLE_LSB +: 2];
  assign field_w[2*`SRC_TIMER_CH3 +: 2] =
    select_four_q[`TIMER_CH3_LSB +: 2];
  assign field_w[2*`SRC_TIMER_CH2 +: 2] =
    select_four_q[`TIMER_CH2_LSB +: 2];
  assign field_w[2*`SRC_TIMER_CH1 +: 2] =
    select_four_q[`TIMER_CH1_LSB +: 2];
  assign field_w[2*`SRC_TIMER_CH0 +: 2] =
    select_four_q[`TIMER_CH0_LSB +: 2];
  assign field_w[2*`SRC_TW_STATUS +: 2] =
    select_four_q[`TW_STATUS_LSB +: 2];
  assign field_w[2*`SRC_TW_TRANSMIT +: 2] =
    select_four_q[`TW_TRANSMIT_LSB +: 2];
  assign field_w[2*`SRC_TW_RECEIVE +: 2] =
    select_four_q[`TW_RECEIVE_LSB +: 2];

  // one decoder per source
  genvar i;
  generate
    for (i = 0; i < N; i = i + 1) begin : g_src
      assign enable_d[i] = enable_of(field_w[2*i +: 2]);
      assign level_d[2*i +: 2] = level_of(field_w[2*i +: 2]);
      assign level0_d[i] = (field_w[2*i +: 2] == `FIELD_LEVEL0);
      assign level1_d[i] = (field_w[2*i +: 2] == `FIELD_LEVEL1);
      assign level2_d[i] = (field_w[2*i +: 2] == `FIELD_LEVEL2);
    end
  endgenerate

  // decoded outputs are registered, so they trail a write by one
  // cycle; this keeps the arbiter off the register write path
  always @(posedge clk_i) begin
    if (reset_i) begin
      enable_q        <= {N{1'b0}};
      level_q         <= {(2*N){1'b0}};
      level0_q        <= {N{1'b0}};
      level1_q        <= {N{1'b0}};
      level2_q        <= {N{1'b0}};
      general_level_q <= `LEVEL_ZERO;
    end else if (ce_i) begin
      enable_q        <= enable_d;
      level_q         <= level_d;
      level0_q        <= level0_d;
      level1_q        <= level1_d;
      level2_q        <= level2_d;
      general_level_q <= level_of(select_four_q[`TW_GENERAL_LSB +: 2]);
    end
  end

  assign rd_data_o        = rd_data_q;
  assign reserved_write_o = reserved_write_q;
  assign src_enable_o     = enable_q;
  assign level0_set_o     = level0_q;
  assign level1_set_o     = level1_q;
  assign level2_set_o     = level2_q;

  assign serial0_tx_empty_level_o =
    level_q[2*`SRC_SER0_TX_EMPTY +: 2];
  assign spi0_tx_empty_level_o    =
    level_q[2*`SRC_SPI0_TX_EMPTY +: 2];
  assign spi0_rx_full_level_o     =
    level_q[2*`SRC_SPI0_RX_FULL +: 2];
  assign port_a_pin_level_o       =
    level_q[2*`SRC_PORT_A +: 2];
  assign port_b_pin_level_o       =
    level_q[2*`SRC_PORT_B +: 2];
  assign port_c_pin_level_o       =
    level_q[2*`SRC_PORT_C +: 2];
  assign twowire_error_level_o    =
    level_q[2*`SRC_TW_ERROR +: 2];
  assign serial0_rx_full_level_o  =
    level_q[2*`SRC_SER0_RX_FULL +: 2];
  assign serial0_rx_error_level_o =
    level_q[2*`SRC_SER0_RX_ERROR +: 2];
  assign serial0_tx_idle_level_o  =
    level_q[2*`SRC_SER0_TX_IDLE +: 2];
  assign timer_ch3_level_o        =
    level_q[2*`SRC_TIMER_CH3 +: 2];
  assign timer_ch2_level_o        =
    level_q[2*`SRC_TIMER_CH2 +: 2];
  assign timer_ch1_level_o        =
    level_q[2*`SRC_TIMER_CH1 +: 2];
  assign timer_ch0_level_o        =
    level_q[2*`SRC_TIMER_CH0 +: 2];
  assign twowire_status_level_o   =
    level_q[2*`SRC_TW_STATUS +: 2];
  assign twowire_transmit_level_o =
    level_q[2*`SRC_TW_TRANSMIT +: 2];
  assign twowire_receive_level_o  =
    level_q[2*`SRC_TW_RECEIVE +: 2];
  assign twowire_general_level_o  = general_level_q;

endmodule

`default_nettype wire

// [hw/prio_cfg_consts.vh]
/*
  Constants for the interrupt priority configuration block: register
  offsets, write masks, reset value, field positions and level codes.
  Assumes a 5-bit word address and 16-bit register data.
*/
`ifndef PRIO_CFG_CONSTS_VH
`define PRIO_CFG_CONSTS_VH

`define ADDR_W              5
`define DATA_W              16
`define SRC_COUNT           17

// word offsets of the three priority registers
`define OFS_SELECT_TWO      5'h02
`define OFS_SELECT_THREE    5'h03
`define OFS_SELECT_FOUR     5'h04

// writable bits; everything else is reserved and reads as zero
`define MASK_SELECT_TWO     16'hC3FF
`define MASK_SELECT_THREE   16'hC03F
`define MASK_SELECT_FOUR    16'hFFFF
`define RESET_VALUE         16'h0000
`define READ_IDLE           16'h0000

// field codes as stored
`define FIELD_OFF           2'h0
`define FIELD_LEVEL0        2'h1
`define FIELD_LEVEL1        2'h2
`define FIELD_LEVEL2        2'h3

// decoded level values
`define LEVEL_ZERO          2'h0
`define LEVEL_ONE           2'h1
`define LEVEL_TWO           2'h2

// field low bits, select_two
`define SER0_TX_EMPTY_LSB   14
`define SPI0_TX_EMPTY_LSB   8
`define SPI0_RX_FULL_LSB    6
`define PORT_A_LSB          4
`define PORT_B_LSB          2
`define PORT_C_LSB          0
// field low bits, select_three
`define TW_ERROR_LSB        14
`define SER0_RX_FULL_LSB    4
`define SER0_RX_ERROR_LSB   2
`define SER0_TX_IDLE_LSB    0
// field low bits, select_four
`define TIMER_CH3_LSB       14
`define TIMER_CH2_LSB       12
`define TIMER_CH1_LSB       10
`define TIMER_CH0_LSB       8
`define TW_STATUS_LSB       6
`define TW_TRANSMIT_LSB     4
`define TW_RECEIVE_LSB      2
`define TW_GENERAL_LSB      0

// source index in the decoded vectors
`define SRC_SER0_TX_EMPTY   0
`define SRC_SPI0_TX_EMPTY   1
`define SRC_SPI0_RX_FULL    2
`define SRC_PORT_A          3
`define SRC_PORT_B          4
`define SRC_PORT_C          5
`define SRC_TW_ERROR        6
`define SRC_SER0_RX_FULL    7
`define SRC_SER0_RX_ERROR   8
`define SRC_SER0_TX_IDLE    9
`define SRC_TIMER_CH3       10
`define SRC_TIMER_CH2       11
`define SRC_TIMER_CH1       12
`define SRC_TIMER_CH0       13
`define SRC_TW_STATUS       14
`define SRC_TW_TRANSMIT     15
`define SRC_TW_RECEIVE      16

`endif

// [verif/prio_cfg_checker.sv]
/*
  Port assertions for the interrupt priority configuration block.
  Assumes it is bound to the block's top module, one clock, and the
  shared constants header on the include path.
*/
`timescale 1ns/100ps
`default_nettype none
`include "prio_cfg_consts.vh"
module prio_cfg_checker (
  input wire logic                  clk_i,
  input wire logic                  reset_i,
  input wire logic                  ce_i,
  input wire logic [`ADDR_W-1:0]    addr_i,
  input wire logic [`DATA_W-1:0]    wr_data_i,
  input wire logic                  wr_i,
  input wire logic                  rd_i,
  input wire logic [`DATA_W-1:0]    rd_data_o,
  input wire logic                  reserved_write_o,
  input wire logic [`SRC_COUNT-1:0] src_enable_o,
  input wire logic [`SRC_COUNT-1:0] level0_set_o,
  input wire logic [`SRC_COUNT-1:0] level1_set_o,
  input wire logic [`SRC_COUNT-1:0] level2_set_o,
  input wire logic [1:0]            timer_ch3_level_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  property p_rst_clear;
    $fell(reset_i) |-> src_enable_o == 17'h00000 && rd_data_o == 16'h0000;
  endproperty
  a_rst_clear: assert property (p_rst_clear)
    else $error("outputs not clear after reset");
  property p_rd_idle;
    ce_i && !rd_i |=> rd_data_o == `READ_IDLE;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not idle");
  property p_rd_two_resv;
    ce_i && rd_i && addr_i == `OFS_SELECT_TWO
      |=> (rd_data_o & ~`MASK_SELECT_TWO) == 16'h0000;
  endproperty
  a_rd_two_resv: assert property (p_rd_two_resv)
    else $error("reserved bits read nonzero in register two");
  property p_rd_three_resv;
    ce_i && rd_i && addr_i == `OFS_SELECT_THREE
      |=> (rd_data_o & ~`MASK_SELECT_THREE) == 16'h0000;
  endproperty
  a_rd_three_resv: assert property (p_rd_three_resv)
    else $error("reserved bits read nonzero in register three");
  property p_rd_unmapped;
    ce_i && rd_i && (addr_i < 5'h02 || addr_i > 5'h04)
      |=> rd_data_o == 16'h0000;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped)
    else $error("unmapped read returned data");
  property p_wr_rd;
    ce_i && rd_i && addr_i == `OFS_SELECT_TWO && !$past(reset_i)
      && $past(ce_i && wr_i && addr_i == `OFS_SELECT_TWO)
      |=> rd_data_o == ($past(wr_data_i, 2) & `MASK_SELECT_TWO);
  endproperty
  a_wr_rd: assert property (p_wr_rd)
    else $error("register two read back wrong");
  property p_flags;
    ((level0_set_o & level1_set_o) | (level0_set_o & level2_set_o)
      | (level1_set_o & level2_set_o)) == 17'h00000
      && src_enable_o == (level0_set_o | level1_set_o | level2_set_o);
  endproperty
  a_flags: assert property (p_flags)
    else $error("level flags inconsistent");
  property p_timer3;
    ce_i && wr_i && addr_i == `OFS_SELECT_FOUR ##1 ce_i
      |=> src_enable_o[`SRC_TIMER_CH3] == |$past(wr_data_i[15:14], 2)
      && timer_ch3_level_o == $past(wr_data_i[15:14], 2)
         - {1'b0, |$past(wr_data_i[15:14], 2)};
  endproperty
  a_timer3: assert property (p_timer3)
    else $error("timer channel 3 decode wrong");
  property p_resv_flag;
    ce_i |=> reserved_write_o == $past(wr_i
      && ((addr_i == `OFS_SELECT_TWO && |(wr_data_i & ~`MASK_SELECT_TWO))
      || (addr_i == `OFS_SELECT_THREE
          && |(wr_data_i & ~`MASK_SELECT_THREE))));
  endproperty
  a_resv_flag: assert property (p_resv_flag)
    else $error("reserved write flag wrong");
endmodule
`default_nettype wire

// [verif/cpu_bus_model.sv]
/*
  Processor-side model of the register port: one-cycle strobes.
  Assumes read data stands in the cycle after the read strobe.
*/
`timescale 1ns/100ps
`default_nettype none
module cpu_bus_model (
  input  wire logic        clk_i,
  input  wire logic [15:0] rdata_i,
  output var  logic [4:0]  addr_o = 5'h00,
  output var  logic [15:0] wdata_o = 16'h0000,
  output var  logic        wr_o = 1'b0,
  output var  logic        rd_o = 1'b0
);
  // released bus shows inverted values so stale data never looks valid
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    wr_o <= 1'b1;
    addr_o <= a;
    wdata_o <= d;
    @(posedge clk_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
    #1;
  endtask
  task automatic rd(input logic [4:0] a, output logic [15:0] q);
    rd_o <= 1'b1;
    addr_o <= a;
    @(posedge clk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    #1;
    q = rdata_i;
  endtask
endmodule
`default_nettype wire

// [verif/interrupt_priority_config_test.sv]
/*
  Self-checking bench for the interrupt priority configuration block.
  Assumes the design, bus model and checker are compiled before it.
*/
`timescale 1ns/100ps
`default_nettype none
`include "prio_cfg_consts.vh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  failures++; $display("Error %s expected %0h seen %0h", n, e, g); end end
module interrupt_priority_config_test;
  logic                  clk_i = 1'b0;
  logic                  reset_i = 1'b1;
  logic                  ce_i = 1'b1;
  wire [`ADDR_W-1:0]     addr_i;
  wire [`DATA_W-1:0]     wr_data_i, rd_data_o;
  wire                   wr_i, rd_i, reserved_write_o;
  wire [`SRC_COUNT-1:0]  src_enable_o, level0_set_o;
  wire [`SRC_COUNT-1:0]  level1_set_o, level2_set_o;
  wire [1:0]             lv [0:17];
  int                    failures = 0;
  int                    cmp_count = 0;
  int                    m [8];
  int                    lsb_t [18] = '{14, 8, 6, 4, 2, 0, 14, 4, 2, 0,
                                        14, 12, 10, 8, 6, 4, 2, 0};
  logic [31:0]           seed = 32'h00014367;
  interrupt_priority_config interrupt_priority_config_i (
    .clk_i, .reset_i, .ce_i, .addr_i, .wr_data_i, .wr_i, .rd_i, .rd_data_o,
    .reserved_write_o, .src_enable_o, .level0_set_o, .level1_set_o,
    .level2_set_o, .serial0_tx_empty_level_o(lv[0]),
    .spi0_tx_empty_level_o(lv[1]), .spi0_rx_full_level_o(lv[2]),
    .port_a_pin_level_o(lv[3]), .port_b_pin_level_o(lv[4]),
    .port_c_pin_level_o(lv[5]), .twowire_error_level_o(lv[6]),
    .serial0_rx_full_level_o(lv[7]), .serial0_rx_error_level_o(lv[8]),
    .serial0_tx_idle_level_o(lv[9]), .timer_ch3_level_o(lv[10]),
    .timer_ch2_level_o(lv[11]), .timer_ch1_level_o(lv[12]),
    .timer_ch0_level_o(lv[13]), .twowire_status_level_o(lv[14]),
    .twowire_transmit_level_o(lv[15]), .twowire_receive_level_o(lv[16]),
    .twowire_general_level_o(lv[17]));
  cpu_bus_model cpu_bus_model_i (.clk_i, .rdata_i(rd_data_o),
    .addr_o(addr_i), .wdata_o(wr_data_i), .wr_o(wr_i), .rd_o(rd_i));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic int mask(input int a);
    case (a)
      2: return `MASK_SELECT_TWO;
      3: return `MASK_SELECT_THREE;
      4: return `MASK_SELECT_FOUR;
      default: return 0;
    endcase
  endfunction
  task automatic put(input int a, input int d);
    logic exp_flag;
    exp_flag = (a == 2 || a == 3) && ((d & ~mask(a) & 16'hFFFF) != 0);
    cpu_bus_model_i.wr(a[4:0], d[15:0]);
    if (ce_i) begin
      `CHK("reserved_write", exp_flag, reserved_write_o)
      if (mask(a) != 0) m[a] = d & mask(a);
    end
  endtask
  task automatic get(input int a);
    logic [15:0] q;
    cpu_bus_model_i.rd(a[4:0], q);
    `CHK("read_data", m[a], q)
  endtask
  // decoded outputs trail the register by one edge
  task automatic check_dec();
    int f;
    logic [3:0] fl;
    @(posedge clk_i);
    #1;
    for (int i = 0; i < 18; i++) begin
      f = (m[i < 6 ? 2 : i < 10 ? 3 : 4] >> lsb_t[i]) & 3;
      `CHK("level", (f == 0) ? 0 : f - 1, lv[i])
      if (i < 17) begin
        fl = {level2_set_o[i], level1_set_o[i], level0_set_o[i],
          src_enable_o[i]};
        `CHK("flags", {f == 3, f == 2, f == 1, f != 0}, fl)
      end
    end
  endtask
  task automatic print_verdict();
    if (failures == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial forever #5 clk_i = ~clk_i;
  initial begin
    // bound far above the cycle budget; a clean run needs under two hundred cycles
    #500000;
    failures++;
    print_verdict();
  end
  initial begin
    logic [31:0] d;
    repeat (5) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    for (int a = 2; a < 5; a++) get(a);
    check_dec();
    for (int c = 0; c < 4; c++) begin
      for (int a = 2; a < 5; a++) begin
        put(a, (c * 16'h5555) & mask(a));
        get(a);
      end
      check_dec();
    end
    put(2, 16'hFFFF);
    get(2);
    put(3, 16'hFFFF);
    get(3);
    // ce low a quarter of the time: a frozen write must not land
    for (int n = 0; n < 60; n++) begin
      d = rnd();
      ce_i <= d[31:30] != 2'h0;
      put(d[18:16], d[15:0]);
      ce_i <= 1'b1;
      get(d[22:20]);
    end
    check_dec();
    reset_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    m = '{default: 0};
    @(posedge clk_i);
    check_dec();
    get(4);
    print_verdict();
  end
endmodule
bind interrupt_priority_config prio_cfg_checker prio_cfg_checker_i (
  .clk_i, .reset_i, .ce_i, .addr_i, .wr_data_i, .wr_i, .rd_i, .rd_data_o,
  .reserved_write_o, .src_enable_o, .level0_set_o, .level1_set_o,
  .level2_set_o, .timer_ch3_level_o);
`default_nettype wire
